// file: csp_cfg.svh
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH
// timing, in kHz, ms, frames and clock cycles
`define CSP_CLK_KHZ       100000
`define CSP_RST_HOLD_MS   50
`define CSP_CAL_FRAMES    10'd194
`define CSP_ZC_FRAMES     10'd512
`define CSP_SLOW_CYC      5'd12
// attenuation code limit for modes a/b, 1.5 dB a step
`define CSP_ATT_MAX_AB    5'd15
// parallel pins per mode
`define CSP_NPAR          4
`define CSP_NPAR_C        2
`define CSP_NPAR_D        1
// sub-frame geometry
`define CSP_SLOT_FULL     7:6
`define CSP_SLOT_HALF     6:5
`define CSP_OFF_FULL      5:0
`define CSP_OFF_HALF      4:0
`define CSP_END_FULL      6'h3f
`define CSP_END_HALF      6'h1f
`define CSP_SW_FULL       9'h040
`define CSP_SW_HALF       9'h020
// 16-bit words of a 64-bit sub-frame, first sent on top
`define CSP_W0            63:48
`define CSP_W1            47:32
`define CSP_W2            31:16
`define CSP_W3            15:0
// control field a, received by the codec
`define CSP_F_GAIN        3:0
`define CSP_F_ATT         8:4
`define CSP_F_MUTE        9
`define CSP_F_POUT        15:12
// status field a, sent by the codec
`define CSP_ERR_NONE      3'h0
`define CSP_ERR_SOFT_PD   3'h1
// controller register map
`define CSP_REG_CTRL      8'h00
`define CSP_REG_TXDATA    8'h04
`define CSP_REG_TXCTRL    8'h08
`define CSP_REG_RXDATA    8'h0c
`define CSP_REG_RXSTAT    8'h10
`define CSP_REG_STATUS    8'h14
`define CSP_C_RUN         0
`define CSP_C_FREQ        15:1
`define CSP_C_MODE        3:1
`define CSP_C_NSUB        5:4
`define CSP_C_SLOT        7:6
`define CSP_C_HALF        15:8
`define CSP_RESP_OKAY     2'h0
`define CSP_RESP_SLVERR   2'h2
`endif

// file: csp_pkg.sv
`include "csp_cfg.svh"
package csp_pkg;
  typedef enum logic [2:0] {
    CSP_MODE_A    = 3'b000,
    CSP_MODE_B    = 3'b001,
    CSP_MODE_C    = 3'b010,
    CSP_MODE_TEST = 3'b011,
    CSP_MODE_D    = 3'b100
  } csp_mode_t;

  typedef enum logic [1:0] {
    CSP_PWR_RUN   = 2'b00,
    CSP_PWR_DRAIN = 2'b01,
    CSP_PWR_OFF   = 2'b10
  } csp_pwr_t;

  typedef struct packed {
    csp_pwr_t    pwr;
    logic        sclk_prev;
    logic [7:0]  cnt;
    logic [7:0]  last;
    logic [63:0] rx;
    logic [63:0] tx;
    logic        sdo;
    logic        sdo_oe;
    logic [15:0] dac_l;
    logic [15:0] dac_r;
    logic [15:0] ctl_a;
    logic [15:0] ctl_b;
    logic [9:0]  frames;
    logic [9:0]  zc;
    logic [4:0]  slow;
    logic        soft_pd;
    logic [3:0]  gain;
    logic [4:0]  atten;
    logic        adc_sign;
    logic        dac_sign;
    logic        mute;
    logic        valid;
    logic [3:0]  pout;
    logic        pout_oe;
  } csp_dev_st_t;

  typedef struct packed {
    logic        wrdy;
    logic        bv;
    logic [1:0]  bresp;
    logic        ardy;
    logic        rv;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [31:0] pend;
    logic [1:0]  chg;
    logic [31:0] txd;
    logic [31:0] txc;
    logic [31:0] rxd;
    logic [31:0] rxs;
    logic [15:0] fcnt;
    logic [22:0] rst_cnt;
    logic        crst_b;
    logic [7:0]  div;
    logic        sclk;
    logic        fs;
    logic        sdo;
    logic [7:0]  cnt;
    logic [63:0] tx;
    logic [63:0] rx;
  } csp_ctl_st_t;

  // sub-frame number of a bit index
  function automatic logic [1:0] csp_slot(input logic [7:0] idx, input logic md_d);
    csp_slot = md_d ? idx[`CSP_SLOT_HALF] : idx[`CSP_SLOT_FULL];
  endfunction : csp_slot

  // position of a bit index inside its sub-frame
  function automatic logic [5:0] csp_off(input logic [7:0] idx, input logic md_d);
    csp_off = md_d ? {1'b0, idx[`CSP_OFF_HALF]} : idx[`CSP_OFF_FULL];
  endfunction : csp_off

  // last bit of a sub-frame
  function automatic logic csp_end(input logic [7:0] idx, input logic md_d);
    csp_end = csp_off(idx, md_d) == (md_d ? `CSP_END_HALF : `CSP_END_FULL);
  endfunction : csp_end

  // byte-lane merge of a register write
  function automatic logic [31:0] csp_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      csp_merge[8*i +: 8] = st[i] ? wd[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : csp_merge
endpackage : csp_pkg

// file: csp_link_if.sv
`timescale 1ns/1ps
interface csp_link_if;
  logic bit_clock;
  logic frame_sync;
  logic serial_data_in;
  logic serial_data_out;
  logic serial_data_out_oe;
  logic serial_data_line;
  logic codec_reset_b;

  // undriven serial output line reads low
  assign serial_data_line = serial_data_out_oe & serial_data_out;

  modport dev (
    input  bit_clock,
    input  frame_sync,
    input  serial_data_in,
    input  codec_reset_b,
    output serial_data_out,
    output serial_data_out_oe
  );

  modport ctl (
    output bit_clock,
    output frame_sync,
    output serial_data_in,
    output codec_reset_b,
    input  serial_data_line
  );
endinterface : csp_link_if

// file: csp_dev.sv
`timescale 1ns/1ps
`include "csp_cfg.svh"
module csp_dev #(
  parameter logic [9:0] FILT_LAT = 10'd16
) (
  // clock and reset
  input  wire logic                  CLK_IN,
  input  wire logic                  RST_B_IN,
  // serial link
  csp_link_if.dev                    LINK,
  // straps
  input  wire logic [2:0]            MODE_STRAP_IN,
  input  wire logic [1:0]            SUBFRAME_SELECT_IN,
  input  wire logic                  POWER_DOWN_PIN_B_IN,
  // converter side
  input  wire logic [15:0]           ADC_LEFT_IN,
  input  wire logic [15:0]           ADC_RIGHT_IN,
  output logic      [15:0]           DAC_LEFT_OUT,
  output logic      [15:0]           DAC_RIGHT_OUT,
  output logic                       DAC_MUTE_OUT,
  output logic      [3:0]            IN_GAIN_OUT,
  output logic      [4:0]            OUT_ATTEN_OUT,
  output logic                       ADC_VALID_OUT,
  output logic                       SOFT_PD_OUT,
  // parallel bit pins
  input  wire logic [`CSP_NPAR-1:0]  PARALLEL_IN,
  output logic      [`CSP_NPAR-1:0]  PARALLEL_OUT,
  output logic                       PARALLEL_OE_OUT
);
  csp_pkg::csp_dev_st_t s;
  csp_pkg::csp_dev_st_t n;
  csp_pkg::csp_mode_t   md;
  logic                 md_d;
  logic                 inv;
  logic                 rise;
  logic                 fall;
  logic                 launch;
  logic                 smp;
  logic [7:0]           nxt;
  logic [7:0]           cnt_s;
  logic                 own_s;
  logic                 own_l;
  logic                 cal_done;
  logic                 valid;
  logic [3:0]           tgt_gain;
  logic [4:0]           tgt_att;
  logic [63:0]          rx_n;
  logic [15:0]          stat;
  logic [63:0]          vec;
  logic [`CSP_NPAR-1:0] pmask;
  logic [9:0]           zc_n;

  // strap decode, high top strap selects mode d
  assign md   = MODE_STRAP_IN[2] ? csp_pkg::CSP_MODE_D : csp_pkg::csp_mode_t'(MODE_STRAP_IN);
  assign md_d = md == csp_pkg::CSP_MODE_D;
  assign inv  = md == csp_pkg::CSP_MODE_A || md == csp_pkg::CSP_MODE_B;

  // bit clock edges, launch and sample edge swap in modes a/b
  assign rise   = LINK.bit_clock & ~s.sclk_prev;
  assign fall   = ~LINK.bit_clock & s.sclk_prev;
  assign launch = inv ? fall : rise;
  assign smp    = inv ? rise : fall;

  // bit index: sync restarts the frame, the length seen last frame predicts the wrap
  assign cnt_s = LINK.frame_sync ? 8'h00 : s.cnt + 8'h01;
  assign nxt   = (s.cnt == s.last) ? 8'h00 : s.cnt + 8'h01;
  assign own_s = csp_pkg::csp_slot(cnt_s, md_d) == SUBFRAME_SELECT_IN && md != csp_pkg::CSP_MODE_TEST;
  assign own_l = csp_pkg::csp_slot(nxt, md_d) == SUBFRAME_SELECT_IN && md != csp_pkg::CSP_MODE_TEST;

  // calibration and filter settling
  assign cal_done = s.frames >= `CSP_CAL_FRAMES && !s.soft_pd;
  assign valid    = s.frames >= `CSP_CAL_FRAMES + FILT_LAT && !s.soft_pd;

  // gain targets, attenuation range narrower in modes a/b
  assign tgt_gain = s.ctl_a[`CSP_F_GAIN];
  assign tgt_att  = (inv && s.ctl_a[`CSP_F_ATT] > `CSP_ATT_MAX_AB) ? `CSP_ATT_MAX_AB
                                                                   : s.ctl_a[`CSP_F_ATT];
  assign zc_n     = s.zc + 10'd1;

  // parallel pins available per mode
  for (genvar i = 0; i < `CSP_NPAR; i++) begin : g_mask
    assign pmask[i] = inv || (md == csp_pkg::CSP_MODE_C && i < `CSP_NPAR_C)
                      || (md_d && i < `CSP_NPAR_D);
  end

  // outgoing sub-frame: audio MSB first, zeros while calibrating
  assign stat = {valid, s.soft_pd ? `CSP_ERR_SOFT_PD : `CSP_ERR_NONE, 8'h00,
                 PARALLEL_IN & pmask};
  assign vec  = md_d ? {cal_done ? ADC_LEFT_IN : 16'h0000, cal_done ? ADC_RIGHT_IN : 16'h0000, 32'h0}
                     : {cal_done ? ADC_LEFT_IN : 16'h0000, stat,
                        cal_done ? ADC_RIGHT_IN : 16'h0000, 16'h0000};
  assign rx_n = {s.rx[62:0], LINK.serial_data_in};

  // next state
  always_comb begin
    n           = s;
    n.sclk_prev = LINK.bit_clock;
    // bit clock period watch, cycles since the last rising edge
    n.slow      = rise ? 5'h00 : ((s.slow == 5'h1f) ? s.slow : s.slow + 5'h01);
    n.soft_pd   = rise ? (s.slow >= `CSP_SLOW_CYC) : (s.soft_pd | (s.slow >= `CSP_SLOW_CYC));
    n.valid     = valid;
    n.mute      = s.ctl_a[`CSP_F_MUTE] | ~cal_done | (s.pwr != csp_pkg::CSP_PWR_RUN);
    case (s.pwr)
      csp_pkg::CSP_PWR_RUN: begin
        if (!POWER_DOWN_PIN_B_IN) begin
          // first drive the serial data output and the parallel pins low
          n.pwr     = csp_pkg::CSP_PWR_DRAIN;
          n.sdo     = 1'b0;
          n.sdo_oe  = 1'b1;
          n.pout    = '0;
          n.pout_oe = 1'b1;
        end else begin
          if (smp) begin
            n.cnt = cnt_s;
            if (LINK.frame_sync) begin
              n.last     = s.cnt;
              n.frames   = (s.frames < `CSP_CAL_FRAMES + FILT_LAT) ? s.frames + 10'd1 : s.frames;
              n.adc_sign = ADC_LEFT_IN[15];
              n.zc       = (s.gain != tgt_gain || s.atten != tgt_att) ? zc_n : 10'd0;
              if (ADC_LEFT_IN[15] != s.adc_sign || zc_n >= `CSP_ZC_FRAMES) begin
                n.gain = tgt_gain;
              end
              if (zc_n >= `CSP_ZC_FRAMES) begin
                n.atten = tgt_att;
                n.zc    = 10'd0;
              end
            end
            // own sub-frame only, others are ignored
            if (own_s) begin
              n.rx = rx_n;
              if (csp_pkg::csp_end(cnt_s, md_d)) begin
                if (md_d) begin
                  n.dac_l = rx_n[`CSP_W2];
                  n.dac_r = rx_n[`CSP_W3];
                end else begin
                  n.dac_l = rx_n[`CSP_W0];
                  n.ctl_a = rx_n[`CSP_W1];
                  n.dac_r = rx_n[`CSP_W2];
                  n.ctl_b = rx_n[`CSP_W3];
                  n.pout  = n.ctl_a[`CSP_F_POUT] & pmask;
                end
                n.dac_sign = n.dac_l[15];
                if (n.dac_l[15] != s.dac_sign) begin
                  n.atten = tgt_att;
                end
              end
            end
          end
          if (launch) begin
            if (own_l) begin
              n.sdo_oe = 1'b1;
              if (csp_pkg::csp_off(nxt, md_d) == 6'h00) begin
                n.sdo = vec[63];
                n.tx  = {vec[62:0], 1'b0};
              end else begin
                n.sdo = s.tx[63];
                n.tx  = {s.tx[62:0], 1'b0};
              end
            end else begin
              n.sdo    = 1'b0;
              n.sdo_oe = 1'b0;
            end
          end
        end
      end
      csp_pkg::CSP_PWR_DRAIN: begin
        // then release them
        n.pwr     = csp_pkg::CSP_PWR_OFF;
        n.sdo_oe  = 1'b0;
        n.pout_oe = 1'b0;
      end
      default: begin
        n.sdo_oe  = 1'b0;
        n.pout_oe = 1'b0;
        if (POWER_DOWN_PIN_B_IN) begin
          // leaving power down restarts calibration
          n.pwr     = csp_pkg::CSP_PWR_RUN;
          n.frames  = 10'd0;
          n.zc      = 10'd0;
          n.pout_oe = 1'b1;
        end
      end
    endcase
  end

  // state register, link reset acts as the codec reset pin
  always_ff @(posedge CLK_IN) begin
    if (!(RST_B_IN && LINK.codec_reset_b)) begin
      s         <= '0;
      s.pout_oe <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // outputs straight from state
  assign LINK.serial_data_out    = s.sdo;
  assign LINK.serial_data_out_oe = s.sdo_oe;
  assign DAC_LEFT_OUT            = s.dac_l;
  assign DAC_RIGHT_OUT           = s.dac_r;
  assign DAC_MUTE_OUT            = s.mute;
  assign IN_GAIN_OUT             = s.gain;
  assign OUT_ATTEN_OUT           = s.atten;
  assign ADC_VALID_OUT           = s.valid;
  assign SOFT_PD_OUT             = s.soft_pd;
  assign PARALLEL_OUT            = s.pout;
  assign PARALLEL_OE_OUT         = s.pout_oe;
endmodule : csp_dev

// file: csp_ctl.sv
`timescale 1ns/1ps
`include "csp_cfg.svh"
module csp_ctl #(
  parameter int unsigned RST_HOLD_CYC = `CSP_RST_HOLD_MS * `CSP_CLK_KHZ
) (
  // clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RST_B_IN,
  // axi4-lite write
  input  wire logic [7:0]  AXI_AWADDR_IN,
  input  wire logic        AXI_AWVALID_IN,
  output logic             AXI_AWREADY_OUT,
  input  wire logic [31:0] AXI_WDATA_IN,
  input  wire logic [3:0]  AXI_WSTRB_IN,
  input  wire logic        AXI_WVALID_IN,
  output logic             AXI_WREADY_OUT,
  output logic [1:0]       AXI_BRESP_OUT,
  output logic             AXI_BVALID_OUT,
  input  wire logic        AXI_BREADY_IN,
  // axi4-lite read
  input  wire logic [7:0]  AXI_ARADDR_IN,
  input  wire logic        AXI_ARVALID_IN,
  output logic             AXI_ARREADY_OUT,
  output logic [31:0]      AXI_RDATA_OUT,
  output logic [1:0]       AXI_RRESP_OUT,
  output logic             AXI_RVALID_OUT,
  input  wire logic        AXI_RREADY_IN,
  // serial link
  csp_link_if.ctl          LINK
);
  csp_pkg::csp_ctl_st_t s;
  csp_pkg::csp_ctl_st_t n;
  logic                 md_d;
  logic                 inv;
  logic [8:0]           tot;
  logic [7:0]           last;
  logic [7:0]           nxt;
  logic [1:0]           tslot;
  logic [15:0]          ctl_a;
  logic [63:0]          tv;
  logic [63:0]          rx_n;
  logic                 running;
  logic [31:0]          wv;

  // link geometry from the control register
  assign md_d    = s.ctrl[3];
  assign inv     = s.ctrl[`CSP_C_MODE] == csp_pkg::CSP_MODE_A || s.ctrl[`CSP_C_MODE] == csp_pkg::CSP_MODE_B;
  assign tot     = (md_d ? `CSP_SW_HALF : `CSP_SW_FULL) << (s.ctrl[5] ? 2'd2 : s.ctrl[`CSP_C_NSUB]);
  assign last    = tot[7:0] - 8'h01;
  assign nxt     = (s.cnt == last) ? 8'h00 : s.cnt + 8'h01;
  assign tslot   = s.ctrl[`CSP_C_SLOT];
  assign running = s.ctrl[`CSP_C_RUN] && s.crst_b;
  assign wv      = csp_pkg::csp_merge(s.ctrl, AXI_WDATA_IN, AXI_WSTRB_IN);

  // outgoing sub-frame, mute bit set while a rate change is under way except in mode d, which sends no control field
  assign ctl_a = s.txc[31:16] | (s.chg != 2'd0 ? 16'h0001 << `CSP_F_MUTE : 16'h0000);
  assign tv    = md_d ? {s.txd, 32'h0} : {s.txd[31:16], ctl_a, s.txd[15:0], s.txc[15:0]};
  assign rx_n  = {s.rx[62:0], LINK.serial_data_line};

  // next state
  always_comb begin
    n = s;
    // write channel: ready once both halves are offered, response after
    if (s.wrdy) begin
      n.wrdy  = 1'b0;
      n.bv    = 1'b1;
      n.bresp = `CSP_RESP_OKAY;
      case (AXI_AWADDR_IN)
        `CSP_REG_CTRL: begin
          if (wv[`CSP_C_FREQ] != s.ctrl[`CSP_C_FREQ]) begin
            n.pend = wv;
            n.chg  = 2'd1;
          end else begin
            n.ctrl = wv;
          end
        end
        `CSP_REG_TXDATA: n.txd = csp_pkg::csp_merge(s.txd, AXI_WDATA_IN, AXI_WSTRB_IN);
        `CSP_REG_TXCTRL: n.txc = csp_pkg::csp_merge(s.txc, AXI_WDATA_IN, AXI_WSTRB_IN);
        `CSP_REG_RXDATA, `CSP_REG_RXSTAT, `CSP_REG_STATUS: n.bresp = `CSP_RESP_OKAY;
        default: n.bresp = `CSP_RESP_SLVERR;
      endcase
    end else if (!s.bv && AXI_AWVALID_IN && AXI_WVALID_IN) begin
      n.wrdy = 1'b1;
    end
    if (s.bv && AXI_BREADY_IN) begin
      n.bv = 1'b0;
    end
    // read channel
    if (s.ardy) begin
      n.ardy  = 1'b0;
      n.rv    = 1'b1;
      n.rresp = `CSP_RESP_OKAY;
      case (AXI_ARADDR_IN)
        `CSP_REG_CTRL:   n.rdata = s.ctrl;
        `CSP_REG_TXDATA: n.rdata = s.txd;
        `CSP_REG_TXCTRL: n.rdata = s.txc;
        `CSP_REG_RXDATA: n.rdata = s.rxd;
        `CSP_REG_RXSTAT: n.rdata = s.rxs;
        `CSP_REG_STATUS: n.rdata = {s.crst_b, s.chg, 13'h0000, s.fcnt};
        default: begin
          n.rdata = 32'h0;
          n.rresp = `CSP_RESP_SLVERR;
        end
      endcase
    end else if (!s.rv && AXI_ARVALID_IN) begin
      n.ardy = 1'b1;
    end
    if (s.rv && AXI_RREADY_IN) begin
      n.rv = 1'b0;
    end
    // codec reset hold
    n.rst_cnt = (s.rst_cnt != 23'h0) ? s.rst_cnt - 23'h1 : 23'h0;
    n.crst_b  = s.rst_cnt == 23'h0;
    // serial engine, bit clock from an even divider
    if (!running) begin
      n.sclk = inv;
      n.fs   = 1'b0;
      n.sdo  = 1'b0;
      n.cnt  = last;
      n.div  = 8'h00;
      if (s.chg != 2'd0) begin
        n.ctrl    = s.pend;
        n.chg     = 2'd0;
        n.rst_cnt = 23'(RST_HOLD_CYC);
      end
    end else if (s.div != 8'h00) begin
      n.div = s.div - 8'h01;
    end else begin
      n.div  = s.ctrl[`CSP_C_HALF] - 8'h01;
      n.sclk = ~s.sclk;
      if (~s.sclk != inv) begin
        // launch edge
        n.cnt = nxt;
        n.fs  = nxt == 8'h00;
        if (nxt == 8'h00) begin
          n.fcnt = s.fcnt + 16'h0001;
          if (s.chg == 2'd1) begin
            n.chg = 2'd2;
          end else if (s.chg == 2'd2) begin
            n.ctrl    = s.pend;
            n.chg     = 2'd0;
            n.rst_cnt = 23'(RST_HOLD_CYC);
          end
        end
        if (csp_pkg::csp_slot(nxt, md_d) == tslot) begin
          if (csp_pkg::csp_off(nxt, md_d) == 6'h00) begin
            n.sdo = tv[63];
            n.tx  = {tv[62:0], 1'b0};
          end else begin
            n.sdo = s.tx[63];
            n.tx  = {s.tx[62:0], 1'b0};
          end
        end else begin
          n.sdo = 1'b0;
        end
      end else if (csp_pkg::csp_slot(s.cnt, md_d) == tslot) begin
        // sample edge
        n.rx = rx_n;
        if (csp_pkg::csp_end(s.cnt, md_d)) begin
          n.rxd = md_d ? {rx_n[`CSP_W2], rx_n[`CSP_W3]} : {rx_n[`CSP_W0], rx_n[`CSP_W2]};
          n.rxs = md_d ? 32'h0 : {rx_n[`CSP_W1], rx_n[`CSP_W3]};
        end
      end
    end
  end

  // state register
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      s         <= '0;
      s.rst_cnt <= 23'(RST_HOLD_CYC);
    end else begin
      s <= n;
    end
  end

  // outputs straight from state
  assign AXI_AWREADY_OUT     = s.wrdy;
  assign AXI_WREADY_OUT      = s.wrdy;
  assign AXI_BVALID_OUT      = s.bv;
  assign AXI_BRESP_OUT       = s.bresp;
  assign AXI_ARREADY_OUT     = s.ardy;
  assign AXI_RVALID_OUT      = s.rv;
  assign AXI_RRESP_OUT       = s.rresp;
  assign AXI_RDATA_OUT       = s.rdata;
  assign LINK.bit_clock      = s.sclk;
  assign LINK.frame_sync     = s.fs;
  assign LINK.serial_data_in = s.sdo;
  assign LINK.codec_reset_b  = s.crst_b;
endmodule : csp_ctl

// file: csp_link_assertions.sv
`timescale 1ns/1ps
module csp_link_assertions #(
  parameter int FRAME_CYC = 384
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  // link lines
  input wire logic bit_clock,
  input wire logic frame_sync,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe,
  input wire logic codec_reset_b
);
  logic [9:0] gap_q;
  logic       seen_q;

  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  // cycles since the last frame start
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      gap_q  <= 10'h000;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= $rose(frame_sync) ? 10'h001 : gap_q + 10'h001;
      seen_q <= seen_q | $rose(frame_sync);
    end
  end

  property p_rst_quiet;
    !codec_reset_b |=> !serial_data_out_oe && !serial_data_out;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("codec output active in reset");
  property p_hold;
    $rose(RST_B_IN) |-> !codec_reset_b [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("codec reset released early");
  property p_fs_width;
    $rose(frame_sync) |-> frame_sync [*6] ##1 !frame_sync;
  endproperty
  a_fs_width: assert property (p_fs_width) else $error("frame sync not one bit long");
  property p_fs_edge;
    $rose(frame_sync) |-> $changed(bit_clock);
  endproperty
  a_fs_edge: assert property (p_fs_edge) else $error("frame sync off a bit edge");
  property p_duty;
    $rose(bit_clock) && codec_reset_b |-> bit_clock [*3] ##1 !bit_clock;
  endproperty
  a_duty: assert property (p_duty) else $error("bit clock duty wrong");
  property p_frame_len;
    $rose(frame_sync) && seen_q |-> gap_q == 10'(FRAME_CYC);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
  property p_sdi_launch;
    $changed(serial_data_in) |-> $rose(bit_clock);
  endproperty
  a_sdi_launch: assert property (p_sdi_launch) else $error("input data off launch edge");
  property p_sdo_launch;
    $changed(serial_data_out) && codec_reset_b && $past(codec_reset_b) |-> $past(bit_clock) && !$past(bit_clock, 2);
  endproperty
  a_sdo_launch: assert property (p_sdo_launch) else $error("output data off launch edge");
endmodule : csp_link_assertions

// file: stereo_codec_serial_port_test.sv
`timescale 1ns/1ps
module stereo_codec_serial_port_test;
  // bench drive and observe
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [15:0] adc_l = 16'h1234;
  logic [15:0] adc_r = 16'h5a5a;
  logic [3:0]  par_in = 4'hd;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  sfs = 2'b00;
  logic        fs_q = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, mute, valid, poe, spd;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, q;
  logic [15:0] dac_l, dac_r;
  logic [3:0]  gain, pout;
  logic [4:0]  att;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          nfs = 0;

  csp_link_if u_csp_link_if ();
  // controller and codec face each other over the link
  csp_ctl #(.RST_HOLD_CYC(8)) u_csp_ctl (.CLK_IN(clk), .RST_B_IN(rst_b), .AXI_AWADDR_IN(awaddr),
    .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb),
    .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid),
    .AXI_BREADY_IN(bready), .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready),
    .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready),
    .LINK(u_csp_link_if.ctl));
  csp_dev #(.FILT_LAT(10'd2)) u_csp_dev (.CLK_IN(clk), .RST_B_IN(rst_b), .LINK(u_csp_link_if.dev),
    .MODE_STRAP_IN(3'b010), .SUBFRAME_SELECT_IN(sfs), .POWER_DOWN_PIN_B_IN(1'b1), .ADC_LEFT_IN(adc_l),
    .ADC_RIGHT_IN(adc_r), .DAC_LEFT_OUT(dac_l), .DAC_RIGHT_OUT(dac_r), .DAC_MUTE_OUT(mute),
    .IN_GAIN_OUT(gain), .OUT_ATTEN_OUT(att), .ADC_VALID_OUT(valid), .SOFT_PD_OUT(spd),
    .PARALLEL_IN(par_in), .PARALLEL_OUT(pout), .PARALLEL_OE_OUT(poe));
  csp_link_assertions #(.FRAME_CYC(384)) u_csp_link_assertions (.CLK_IN(clk), .RST_B_IN(rst_b),
    .bit_clock(u_csp_link_if.bit_clock), .frame_sync(u_csp_link_if.frame_sync),
    .serial_data_in(u_csp_link_if.serial_data_in), .serial_data_out(u_csp_link_if.serial_data_out),
    .serial_data_out_oe(u_csp_link_if.serial_data_out_oe), .codec_reset_b(u_csp_link_if.codec_reset_b));

  // 100 mhz clock
  always #5 clk = ~clk;

  // count frame starts on the link
  always @(posedge clk) begin
    fs_q <= u_csp_link_if.frame_sync;
    if (u_csp_link_if.frame_sync === 1'b1 && fs_q === 1'b0) nfs <= nfs + 1;
  end

  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] s);
    int i;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; (awready & wready) !== 1'b1 && i < 200; i++) @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    for (; bvalid !== 1'b1 && i < 200; i++) @(posedge clk);
    s = bresp;
    if (i >= 200) begin
      n_fail++;
      summarize();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; arready !== 1'b1 && i < 200; i++) @(posedge clk);
    arvalid <= 1'b0;
    for (; rvalid !== 1'b1 && i < 200; i++) @(posedge clk);
    d = rdata;
    s = rresp;
    if (i >= 200) begin
      n_fail++;
      summarize();
    end
  endtask : axi_rd

  task automatic wait_frames(input int n);
    int t;
    t = nfs + n;
    for (int i = 0; i < n * 500 && nfs < t; i++) @(posedge clk);
    if (nfs < t) begin
      n_fail++;
      summarize();
    end
  endtask : wait_frames

  task automatic wait_lvl(ref logic s, input logic v);
    for (int i = 0; i < 90000 && s !== v; i++) @(posedge clk);
    if (s !== v) begin
      n_fail++;
      summarize();
    end
  endtask : wait_lvl

  // reset state, unmapped place, start the link in mode c
  task automatic t_regs;
    chk(u_csp_link_if.codec_reset_b, 1'b0);
    chk({poe, pout, dac_l}, {1'b1, 20'h0});
    axi_rd(8'h00, q, r);
    chk(q, 32'h0);
    axi_wr(8'h40, 32'hffff_ffff, r);
    chk(r, 2'h2);
    axi_rd(8'h40, q, r);
    chk({r, q}, {2'h2, 32'h0});
    axi_wr(8'h00, 32'h0000_0305, r);
    axi_rd(8'h00, q, r);
    chk({r, q}, {2'h0, 32'h0000_0305});
  endtask : t_regs

  // calibration mute, zero data, valid delay
  task automatic t_cal;
    wait_frames(10);
    chk({mute, valid}, 2'b10);
    axi_rd(8'h0c, q, r);
    chk(q, 32'h0);
    wait_lvl(mute, 1'b0);
    chk(nfs >= 194 && nfs <= 195, 1'b1);
    wait_lvl(valid, 1'b1);
    chk(nfs >= 196 && nfs <= 197, 1'b1);
  endtask : t_cal

  // levels wait for a sign change, then data and pins cross
  task automatic t_data;
    axi_wr(8'h04, 32'h1111_2222, r);
    axi_wr(8'h08, 32'ha145_0000, r);
    wait_frames(3);
    chk({gain, att}, 9'h0);
    adc_l <= 16'hf234;
    axi_wr(8'h04, 32'h9abc_5678, r);
    wait_frames(4);
    chk({gain, att}, {4'd5, 5'd20});
    chk(pout, 4'h2);
    chk(spd, 1'b0);
    chk({dac_l, dac_r}, 32'h9abc_5678);
    axi_rd(8'h0c, q, r);
    chk(q, {16'hf234, 16'h5a5a});
    axi_rd(8'h10, q, r);
    chk(q[31:16], 16'h8001);
  endtask : t_data

  // foreign sub-frame: input ignored, output released; partial strobe write
  task automatic t_slot;
    sfs <= 2'b01;
    wstrb <= 4'h3;
    axi_wr(8'h04, 32'h0123_4567, r);
    wstrb <= 4'hf;
    axi_rd(8'h04, q, r);
    chk(q, 32'h9abc_4567);
    wait_frames(3);
    chk({dac_l, dac_r}, 32'h9abc_5678);
    chk(u_csp_link_if.serial_data_out_oe, 1'b0);
    axi_rd(8'h0c, q, r);
    chk(q, 32'h0);
  endtask : t_slot

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs();
    t_cal();
    t_data();
    t_slot();
    summarize();
  end
endmodule : stereo_codec_serial_port_test
